/* File: rtl/flm_pkg.sv */
// constants and types shared by the flash led mode control block
// assumes a single 125 MHz core clock and active-low async reset
package flm_pkg;
    // ===========================================
    // led operating modes
    typedef enum logic [2:0] {
        FLM_SHUTDOWN,
        FLM_TORCH,
        FLM_ASSIST,
        FLM_RESERVED,
        FLM_FLASH
    } flm_mode_t;

    // ===========================================
    // current level codes driven to the analog current source
    localparam logic [1:0] FLM_LVL_OFF = 2'h0;
    localparam logic [1:0] FLM_LVL_LOW = 2'h1;
    localparam logic [1:0] FLM_LVL_FULL = 2'h2;

    // ===========================================
    // serial bus addresses (write byte / read byte) and 7-bit form
    localparam logic [7:0] FLM_WR_ADDR_BYTE = 8'h60;
    localparam logic [7:0] FLM_RD_ADDR_BYTE = 8'h61;
    localparam logic [6:0] FLM_DEV_ADDR = FLM_WR_ADDR_BYTE[7:1];

    // reset values
    localparam logic [2:0] FLM_LVL_SET_RST = 3'h1;
    localparam logic FLM_FAULT_RST = 1'b0;
endpackage

/* File: rtl/flm_mode_ctrl.sv */
// mode decoder and led enable logic for a flash led driver
// assumes pins are asynchronous and pass through two-flop synchronisers;
// the serial protocol engine outside supplies the decoded bus requests
`timescale 1ns/1ps

module flm_mode_ctrl
    import flm_pkg::*;
(
    input wire logic core_clk_i,            // 125 MHz core clock
    input wire logic rstn_i,                // async reset, active low
    input wire logic if_select_i,           // interface select pin
    input wire logic clock_or_mode_bit1_i,  // dual-role pin one
    input wire logic data_or_mode_bit2_i,   // dual-role pin two (in)
    input wire logic torch_i,               // torch pin
    input wire logic tx_mask_i,             // transmit mask pin
    input wire logic strobe_i,              // strobe pin input side
    input wire logic boost_ov_i,            // overvoltage comparator
    input wire logic led_two_i,             // led count comparator
    input wire logic [6:0] bus_addr_i,      // address seen by bus engine
    input wire logic bus_addr_vld_i,        // one-cycle address strobe
    input wire logic bus_assist_i,          // assist requested by reg
    input wire logic bus_flash_i,           // flash requested by reg
    input wire logic bus_torch_en_i,        // torch enable by reg
    input wire logic [2:0] bus_lvl_set_i,   // torch/assist current code
    input wire logic fault_clr_i,           // one-cycle fault clear
    output logic strobe_o,                  // strobe pin drive value
    output logic strobe_oe_o,               // strobe pin output enable
    output logic [2:0] mode_o,              // current operating mode
    output logic [1:0] level_o,             // current level class
    output logic [2:0] lvl_set_o,           // low current code applied
    output logic driver_en_o,               // led driver on
    output logic fault_ov_o,                // sticky overvoltage fault
    output logic addr_match_o               // bus address matched
);

    // ===========================================
    // pin synchronisers
    logic [6:0] s1_r;
    logic [6:0] s2_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 7'h00;
            s2_r <= 7'h00;
        end else begin
            s1_r <= {led_two_i, boost_ov_i, strobe_i, tx_mask_i,
                     torch_i, data_or_mode_bit2_i,
                     clock_or_mode_bit1_i};
            s2_r <= s1_r;
        end
    end

    wire mode_bit_one = s2_r[0];
    wire mode_bit_two = s2_r[1];
    wire torch_s = s2_r[2];
    wire mask_s = s2_r[3];
    wire strobe_s = s2_r[4];
    wire ov_s = s2_r[5];
    wire led_two_s = s2_r[6];

    logic sel1_r;
    logic sel_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel1_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            sel1_r <= if_select_i;
            sel_r <= sel1_r;
        end
    end

    // ===========================================
    // request decode
    wire serial_mode = sel_r;
    // two-bit logic: 00 torch/off, 01 assist, 10 reserved, 11 flash
    wire l_flash = !serial_mode && mode_bit_one && mode_bit_two;
    wire l_assist = !serial_mode && !mode_bit_one && mode_bit_two;
    wire l_rsvd = !serial_mode && mode_bit_one && !mode_bit_two;
    wire l_torch = !serial_mode && !mode_bit_one && !mode_bit_two
                   && torch_s;
    // strobe input only counts in serial mode
    wire s_flash = serial_mode && (bus_flash_i || strobe_s);
    wire s_assist = serial_mode && bus_assist_i;
    wire s_torch = serial_mode && bus_torch_en_i && torch_s;

    wire req_flash = l_flash || s_flash;
    wire req_assist = l_assist || s_assist;
    wire req_torch = l_torch || s_torch;

    // flash beats assist beats torch
    logic fault_ov_r;
    flm_mode_t mode_nxt;
    always_comb begin
        if (fault_ov_r) begin
            mode_nxt = FLM_SHUTDOWN;
        end else if (req_flash) begin
            mode_nxt = FLM_FLASH;
        end else if (req_assist) begin
            mode_nxt = FLM_ASSIST;
        end else if (l_rsvd) begin
            mode_nxt = FLM_RESERVED;
        end else if (req_torch) begin
            mode_nxt = FLM_TORCH;
        end else begin
            mode_nxt = FLM_SHUTDOWN;
        end
    end

    // ===========================================
    // mode state and outputs
    flm_mode_t mode_r;
    logic [1:0] level_nxt;
    always_comb begin
        case (mode_nxt)
            FLM_FLASH: level_nxt = mask_s ? FLM_LVL_LOW
                                          : FLM_LVL_FULL;
            FLM_ASSIST: level_nxt = FLM_LVL_LOW;
            FLM_TORCH: level_nxt = FLM_LVL_LOW;
            default: level_nxt = FLM_LVL_OFF;
        endcase
    end

    // fault set wins over a clear in the same cycle
    wire fault_nxt = ov_s || (fault_ov_r && !fault_clr_i);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= FLM_SHUTDOWN;
            level_o <= FLM_LVL_OFF;
            driver_en_o <= 1'b0;
            fault_ov_r <= FLM_FAULT_RST;
            lvl_set_o <= FLM_LVL_SET_RST;
        end else begin
            mode_r <= mode_nxt;
            level_o <= level_nxt;
            // ov gates the driver at once; the mode only catches up
            // with the fault flop one edge later
            driver_en_o <= (level_nxt != FLM_LVL_OFF) && !ov_s;
            fault_ov_r <= fault_nxt;
            lvl_set_o <= bus_lvl_set_i;
        end
    end
    assign mode_o = mode_r;
    assign fault_ov_o = fault_ov_r;

    // ===========================================
    // strobe pin direction and bus address match
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strobe_o <= 1'b0;
            strobe_oe_o <= 1'b0;
            addr_match_o <= 1'b0;
        end else begin
            strobe_o <= !serial_mode && led_two_s;
            strobe_oe_o <= !serial_mode;
            addr_match_o <= serial_mode && bus_addr_vld_i
                            && (bus_addr_i == FLM_DEV_ADDR);
        end
    end

    // ===========================================
    // checks
    // pins reach the decode two edges late: pin-level sequences span
    // three samples before the mode register is judged
    sequence ov_seen;
        ov_s;
    endsequence

    sequence flash_pins;
        !if_select_i && clock_or_mode_bit1_i && data_or_mode_bit2_i;
    endsequence

    sequence assist_held;
        mode_r == FLM_ASSIST;
    endsequence

    sequence flash_asked;
        req_flash && !fault_ov_r;
    endsequence

    // overvoltage and the sticky fault
    a_ov_kills_drv: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) ov_seen |=> !driver_en_o && fault_ov_o)
        else $error("driver on during overvoltage");

    a_fault_sticky: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) fault_ov_o && !fault_clr_i |=> fault_ov_o)
        else $error("fault lost without a clear");

    a_fault_clear: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) fault_ov_o && fault_clr_i && !ov_s
        |=> !fault_ov_o) else $error("fault clear ignored");

    a_fault_off: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) fault_ov_o |-> !driver_en_o)
        else $error("driver on with fault recorded");

    a_fault_shut: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) fault_ov_o
        |=> mode_r == FLM_SHUTDOWN && level_o == FLM_LVL_OFF)
        else $error("mode kept under fault");

    // mode selection and priority
    a_flash_prio: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) flash_asked |=> mode_r == FLM_FLASH)
        else $error("flash lost");

    a_assist_to_flash: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) assist_held ##0 flash_asked
        |=> mode_r == FLM_FLASH) else $error("assist did not go to flash");

    a_assist_steady: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) req_assist && !req_flash && !fault_ov_r
        |=> mode_r == FLM_ASSIST && level_o == FLM_LVL_LOW)
        else $error("assist not steady");

    a_torch_blocked: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) req_assist && !fault_ov_r
        |=> mode_r != FLM_TORCH) else $error("torch over assist");

    a_torch_on: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) req_torch && !req_flash && !req_assist
        && !fault_ov_r |=> mode_r == FLM_TORCH)
        else $error("torch not taken");

    a_shared_level: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) mode_r == FLM_TORCH || mode_r == FLM_ASSIST
        |-> level_o == FLM_LVL_LOW) else $error("level split");

    a_lvl_copy: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) 1'b1 |=> lvl_set_o == $past(bus_lvl_set_i))
        else $error("current code not applied");

    a_mask_low: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) mode_nxt == FLM_FLASH && mask_s
        |=> level_o == FLM_LVL_LOW && mode_r == FLM_FLASH)
        else $error("mask not applied");

    a_mask_release: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) mode_nxt == FLM_FLASH && !mask_s
        |=> level_o == FLM_LVL_FULL) else $error("no full");

    // two-bit logic decode
    a_shutdown: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !serial_mode && !mode_bit_one
        && !mode_bit_two && !torch_s |=> mode_r == FLM_SHUTDOWN
        && !driver_en_o) else $error("no shutdown");

    a_bit_one: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !serial_mode && mode_bit_one && mode_bit_two
        && !fault_ov_r |=> mode_r == FLM_FLASH) else $error("bit one lost");

    a_bit_two: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !serial_mode && !mode_bit_one && mode_bit_two
        && !fault_ov_r |=> mode_r == FLM_ASSIST) else $error("bit two lost");

    a_rsvd_dark: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) l_rsvd && !fault_ov_r
        |=> mode_r == FLM_RESERVED && level_o == FLM_LVL_OFF)
        else $error("reserved not dark");

    a_pin_decode: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) flash_pins [*3] ##0 !fault_ov_r
        |=> mode_r == FLM_FLASH) else $error("pins did not select flash");

    a_serial_pins: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) serial_mode && !bus_flash_i && !strobe_s
        && !bus_assist_i && !bus_torch_en_i && !fault_ov_r
        |=> mode_r == FLM_SHUTDOWN) else $error("pins used in serial");

    // strobe pin and bus address
    a_strobe_dir: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) serial_mode |=> !strobe_oe_o)
        else $error("strobe driven in serial");

    a_strobe_low: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) serial_mode |=> !strobe_o)
        else $error("strobe high in serial");

    a_strobe_cnt: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !serial_mode |=> strobe_oe_o
        && strobe_o == $past(led_two_s)) else $error("bad count");

    a_addr_hit: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) serial_mode && bus_addr_vld_i
        && bus_addr_i == 7'h30 |=> addr_match_o)
        else $error("address missed");

    a_addr_miss: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !(serial_mode && bus_addr_vld_i)
        |=> !addr_match_o) else $error("match without address");
endmodule

/* File: sim/flm_host_model.sv */
// host model: drives the control pins of the flash led block
// assumes the bench sets cmd_i at the falling clock edge
`timescale 1ns/1ps
module flm_host_model (
    input wire logic [5:0] cmd_i,      // select,bit1,bit2,torch,mask,strobe
    input wire logic [7:0] addr_byte_i, // address byte the host sends
    input wire logic oe_i,             // device strobe enable
    input wire logic drv_i,            // device strobe value
    output logic if_select_o,          // interface select pin
    output logic bit1_o,               // dual-role pin one
    output logic bit2_o,               // dual-role pin two
    output logic torch_o,              // torch pin
    output logic mask_o,               // transmit mask pin
    output logic strobe_o,             // resolved strobe wire
    output logic [6:0] bus_addr_o      // address seen by the bus engine
);
    assign if_select_o = cmd_i[5];
    assign bit1_o = cmd_i[4];
    assign bit2_o = cmd_i[3];
    assign torch_o = cmd_i[2];
    assign mask_o = cmd_i[1];
    // host lets go of the strobe wire whenever the device drives it
    assign strobe_o = oe_i ? drv_i : cmd_i[0];
    assign bus_addr_o = addr_byte_i[7:1];
endmodule

/* File: sim/flm_mode_ctrl_tb.sv */
// self-checking bench for the flash led mode control block
// assumes the host model owns the pins; the bench drives the rest
`timescale 1ns/1ps
module flm_mode_ctrl_tb;
    import flm_pkg::*;
    // ====================
    // stimulus and wiring
    logic clk = 0, rstn = 0, sel = 0, en1 = 0, en2 = 0, tch = 0, txm = 0;
    logic ov = 0, two = 0, bfl = 0, bas = 0, bte = 0, avld = 0, fclr = 0;
    logic hstb = 0, flt = 0;
    logic [2:0] lvl = 3'h0;
    logic [7:0] abyte = 8'h00;
    wire ps, p1, p2, pt, pm, pst, so, soe, drv, fo, am;
    wire [6:0] ba;
    wire [2:0] mode, lset;
    wire [1:0] lev;
    int num_errors = 0, tests_run = 0;
    always #4 clk = ~clk;
    flm_host_model i_flm_host_model (.cmd_i({sel, en1, en2, tch, txm, hstb}),
        .addr_byte_i(abyte), .oe_i(soe), .drv_i(so), .if_select_o(ps),
        .bit1_o(p1), .bit2_o(p2), .torch_o(pt), .mask_o(pm),
        .strobe_o(pst), .bus_addr_o(ba));
    flm_mode_ctrl i_flm_mode_ctrl (.core_clk_i(clk), .rstn_i(rstn),
        .if_select_i(ps), .clock_or_mode_bit1_i(p1),
        .data_or_mode_bit2_i(p2), .torch_i(pt), .tx_mask_i(pm),
        .strobe_i(pst), .boost_ov_i(ov), .led_two_i(two), .bus_addr_i(ba),
        .bus_addr_vld_i(avld), .bus_assist_i(bas), .bus_flash_i(bfl),
        .bus_torch_en_i(bte), .bus_lvl_set_i(lvl), .fault_clr_i(fclr),
        .strobe_o(so), .strobe_oe_o(soe), .mode_o(mode), .level_o(lev),
        .lvl_set_o(lset), .driver_en_o(drv), .fault_ov_o(fo),
        .addr_match_o(am));
    // ====================
    // checking
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [2:0] exp, logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // reference model; waits out the two-flop pin synchronisers and the
    // strobe wire turnaround, whose old driven level is synchronised too
    task automatic check_state();
        int m, l;
        bit fl, as, to;
        fl = sel ? (bfl | hstb) : (en1 & en2);
        as = sel ? bas : (!en1 & en2);
        to = sel ? (bte & tch) : tch;
        m = fl ? 4 : as ? 2 : (!sel & en1) ? 3 : to ? 1 : 0;
        m = flt ? 0 : m;
        l = (m == 4) ? (txm ? 1 : 2) : (m == 1 || m == 2) ? 1 : 0;
        repeat (6) @(negedge clk);
        chk("mode", m[2:0], mode);
        chk("level", l[2:0], {1'b0, lev});
        chk("drive", {2'b0, l != 0}, {2'b0, drv});
        chk("strobe", {1'b0, !sel, !sel & two}, {1'b0, soe, so});
        chk("setting", lvl, lset);
        chk("fault", {2'b0, flt}, {2'b0, fo});
    endtask
    // ====================
    // sequence
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
    initial begin
        int i, r;
        r = $urandom(32'h26eb_fe6f);
        repeat (16) @(negedge clk);
        rstn = 1;
        for (i = 0; i < 32; i++) begin
            {en1, en2, tch, txm, two} = i[4:0];
            lvl = 3'($urandom);
            check_state();
        end
        sel = 1;
        for (i = 0; i < 48; i++) begin
            r = $urandom;
            {bfl, bas, bte, tch, txm, hstb, en1, en2} = r[7:0];
            lvl = r[10:8];
            check_state();
        end
        {bfl, bas, hstb, txm} = 4'b0100;
        check_state();
        hstb = 1;
        check_state();
        // the clear is refused while the overvoltage persists
        ov = 1;
        flt = 1;
        check_state();
        fclr = 1;
        @(negedge clk);
        fclr = 0;
        ov = 0;
        check_state();
        fclr = 1;
        @(negedge clk);
        fclr = 0;
        flt = 0;
        check_state();
        for (i = 0; i < 3; i++) begin
            abyte = i == 0 ? FLM_WR_ADDR_BYTE : i == 1 ? FLM_RD_ADDR_BYTE
                : 8'h62;
            avld = 1;
            @(negedge clk);
            avld = 0;
            chk("match", {2'b0, i < 2}, {2'b0, am});
            @(negedge clk);
            chk("match_end", 3'h0, {2'b0, am});
        end
        // back to logic mode: the bus address must be refused there
        sel = 0;
        check_state();
        abyte = FLM_WR_ADDR_BYTE;
        avld = 1;
        @(negedge clk);
        avld = 0;
        chk("match_logic", 3'h0, {2'b0, am});
        end_sim();
    end
endmodule
